// *** lscsm_top.sv ***
// low-speed wake-up clock shift meter with avalon-mm register slave
// assumes clock is the accurate master clock; wake clocks are slow and asynchronous
//
// What this block does
// - counts fast master clock cycles over a wake clock window; count readable by host.
// - window lasts window-setting wake periods; setting is bits 5-0 of window register.
// - counted clock is master clock divided by config bits 7-4.
// - division setting zero counts the undivided master clock.
// - count split: upper byte at index 0x72, lower byte at 0x73, read-only.
// - wake clock is external input or internal rc, chosen by sleep config bit 2.
`include "lscsm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module lscsm_top #(
  parameter int CNT_W = 16,
  parameter int WIN_W = 6,
  parameter int DIV_W = 4
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // wake-up clock sources
  input  wire logic        ext_wake_clk,
  input  wire logic        rc_wake_clk,
  // avalon-mm slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // interrupt
  output logic             irq
);
  generate
    if (CNT_W != 16 || WIN_W < 1 || WIN_W > 8 || DIV_W < 1 || DIV_W > 4) begin : g_bad
      $error("lscsm_top: unsupported parameter values");
    end
  endgenerate

  typedef struct packed {
    lscsm_pkg::lscsm_state_t st;
    logic [7:0]              cfg;
    logic [7:0]              win;
    logic [7:0]              swcfg;
    logic [CNT_W-1:0]        result;
    logic [CNT_W-1:0]        cnt;
    logic [WIN_W-1:0]        wcnt;
    logic [DIV_W-1:0]        divcnt;
    logic                    done;
    logic                    mask;
    logic                    ack;
    logic [7:0]              rdata;
    logic                    wk_prev;
  } lscsm_top_t;

  lscsm_top_t s_q;
  lscsm_top_t s_d;
  logic       rst_sync_n;
  logic       ext_s;
  logic       rc_s;
  logic       wk_s;
  logic       req;
  logic       wr_take;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic       wk_edge;
  logic       tick;
  logic       start;
  logic       done_evt;
  logic [WIN_W-1:0] win_len;
  logic [DIV_W-1:0] div;

  lscsm_sync u_rst_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     (1'b1),
    .q     (rst_sync_n)
  );
  lscsm_sync u_ext_sync (
    .clock (clock),
    .rst_n (rst_sync_n),
    .d     (ext_wake_clk),
    .q     (ext_s)
  );
  lscsm_sync u_rc_sync (
    .clock (clock),
    .rst_n (rst_sync_n),
    .d     (rc_wake_clk),
    .q     (rc_s)
  );

  // mux after both synchronisers so switching source never glitches a flop input
  assign wk_s    = s_q.swcfg[`LSCSM_WAKE_SEL_BIT] ? rc_s : ext_s;
  assign wk_edge = wk_s & ~s_q.wk_prev;
  assign req     = avs_read | avs_write;
  assign wr_take = avs_write & s_q.ack;
  assign idx     = avs_address[9:2];
  assign wbyte   = avs_writedata[7:0];
  assign win_len = s_q.win[`LSCSM_WIN_LSB +: WIN_W];
  assign div     = s_q.cfg[`LSCSM_DIV_MSB -: DIV_W];
  // zero setting means every master cycle counts
  assign tick    = (div == '0) || (s_q.divcnt == div - 1'b1);
  assign start   = wr_take && (idx == `LSCSM_IDX_MEASURE_CONTROL)
                   && wbyte[`LSCSM_START_BIT];

  always_comb begin
    s_d         = s_q;
    done_evt    = 1'b0;
    s_d.wk_prev = wk_s;
    s_d.ack     = req & ~s_q.ack;
    if (s_q.st == lscsm_pkg::LSCSM_RUN) begin
      if (tick) begin
        s_d.divcnt = '0;
        // saturate rather than wrap so an overlong window reads as full scale
        if (s_q.cnt != '1) begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end else begin
        s_d.divcnt = s_q.divcnt + 1'b1;
      end
    end
    unique case (s_q.st)
      lscsm_pkg::LSCSM_IDLE: begin
      end
      lscsm_pkg::LSCSM_ARM: begin
        if (wk_edge) begin
          s_d.cnt    = '0;
          s_d.wcnt   = '0;
          s_d.divcnt = '0;
          if (win_len == '0) begin
            s_d.result = '0;
            done_evt   = 1'b1;
            s_d.st     = lscsm_pkg::LSCSM_IDLE;
          end else begin
            s_d.st = lscsm_pkg::LSCSM_RUN;
          end
        end
      end
      lscsm_pkg::LSCSM_RUN: begin
        if (wk_edge) begin
          s_d.wcnt = s_q.wcnt + 1'b1;
          if (s_q.wcnt + 1'b1 == win_len) begin
            s_d.result = s_q.cnt;
            done_evt   = 1'b1;
            s_d.st     = lscsm_pkg::LSCSM_IDLE;
          end
        end
      end
      default: begin
        s_d.st = lscsm_pkg::LSCSM_IDLE;
      end
    endcase
    if (start) begin
      s_d.st = lscsm_pkg::LSCSM_ARM;
    end
    // read data captured in the wait cycle, stands while waitrequest is low
    if (req && !s_q.ack) begin
      unique case (idx)
        `LSCSM_IDX_SLEEP_WAKEUP_CONFIG:  s_d.rdata = s_q.swcfg;
        `LSCSM_IDX_SHIFT_MEASURE_CONFIG: s_d.rdata = s_q.cfg;
        `LSCSM_IDX_SHIFT_MEASURE_WINDOW: s_d.rdata = s_q.win;
        `LSCSM_IDX_SHIFT_COUNT_HIGH:     s_d.rdata = s_q.result[15:8];
        `LSCSM_IDX_SHIFT_COUNT_LOW:      s_d.rdata = s_q.result[7:0];
        `LSCSM_IDX_MEASURE_CONTROL:
          s_d.rdata = {6'h00, (s_q.st != lscsm_pkg::LSCSM_IDLE), 1'b0};
        `LSCSM_IDX_INT_STATUS:           s_d.rdata = {7'h00, s_q.done};
        `LSCSM_IDX_INT_MASK:             s_d.rdata = {7'h00, s_q.mask};
        default:                         s_d.rdata = 8'h00;
      endcase
    end
    if (wr_take) begin
      unique case (idx)
        `LSCSM_IDX_SLEEP_WAKEUP_CONFIG:  s_d.swcfg = wbyte;
        `LSCSM_IDX_SHIFT_MEASURE_CONFIG: s_d.cfg   = wbyte;
        `LSCSM_IDX_SHIFT_MEASURE_WINDOW: s_d.win   = wbyte;
        `LSCSM_IDX_INT_MASK:             s_d.mask  = wbyte[`LSCSM_DONE_BIT];
        `LSCSM_IDX_INT_STATUS: begin
          if (wbyte[`LSCSM_DONE_BIT]) begin
            s_d.done = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // a completion in the clearing cycle still sets the flag
    if (done_evt) begin
      s_d.done = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_q <= '{st: lscsm_pkg::LSCSM_IDLE, cfg: `LSCSM_RST_BYTE, win: `LSCSM_RST_BYTE,
               swcfg: `LSCSM_RST_BYTE, result: `LSCSM_RST_COUNT, cnt: '0, wcnt: '0,
               divcnt: '0, done: 1'b0, mask: 1'b0, ack: 1'b0, rdata: 8'h00,
               wk_prev: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata    = {24'h000000, s_q.rdata};
  assign avs_waitrequest = req & ~s_q.ack;
  assign irq             = s_q.done & s_q.mask;
endmodule // lscsm_top
`default_nettype wire

// *** lscsm_defines.svh ***
// offsets, field positions and reset values of the clock shift meter
// assumes a word-indexed register map: byte address is four times the index
`ifndef LSCSM_DEFINES_SVH
`define LSCSM_DEFINES_SVH
`define LSCSM_IDX_SLEEP_WAKEUP_CONFIG 8'h2d
`define LSCSM_IDX_SHIFT_MEASURE_CONFIG 8'h70
`define LSCSM_IDX_SHIFT_MEASURE_WINDOW 8'h71
`define LSCSM_IDX_SHIFT_COUNT_HIGH    8'h72
`define LSCSM_IDX_SHIFT_COUNT_LOW     8'h73
`define LSCSM_IDX_MEASURE_CONTROL     8'h74
`define LSCSM_IDX_INT_STATUS          8'h75
`define LSCSM_IDX_INT_MASK            8'h76
`define LSCSM_WAKE_SEL_BIT            2
`define LSCSM_DIV_MSB                 7
`define LSCSM_DIV_LSB                 4
`define LSCSM_WIN_MSB                 5
`define LSCSM_WIN_LSB                 0
`define LSCSM_START_BIT               0
`define LSCSM_BUSY_BIT                1
`define LSCSM_DONE_BIT                0
`define LSCSM_RST_BYTE                8'h00
`define LSCSM_RST_COUNT               16'h0000
`endif

// *** lscsm_pkg.sv ***
// types shared by the clock shift meter
// assumes the defines header is compiled alongside
package lscsm_pkg;
  typedef enum logic [1:0] {
    LSCSM_IDLE = 2'b00,
    LSCSM_ARM  = 2'b01,
    LSCSM_RUN  = 2'b11
  } lscsm_state_t;
endpackage

// *** lscsm_sync.sv ***
// two flip-flop synchroniser, also used as reset release with d tied high
// assumes d comes from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module lscsm_sync (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // data
  input  wire logic d,
  output logic      q
);
  typedef struct packed {
    logic stage1;
    logic stage2;
  } lscsm_sync_t;
  lscsm_sync_t s_q;
  lscsm_sync_t s_d;
  always_comb begin
    s_d.stage1 = d;
    s_d.stage2 = s_q.stage1;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign q = s_q.stage2;
endmodule // lscsm_sync
`default_nettype wire

// *** lscsm_properties.sv ***
// port assertions of the clock shift meter
// assumes a bind from the bench top file
`timescale 1ns/1ps
`default_nettype none
module lscsm_properties (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // bus and interrupt
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic req = avs_read | avs_write;
  wire logic ack = req & !avs_waitrequest;
  a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("no wait cycle");
  a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait too long");
  a_rd_upper: assert property (ack && avs_read |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_rd_unmapped: assert property (
    ack && avs_read && avs_address[9:2] == 8'h00 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (!req |=> $stable(avs_readdata))
    else $error("read data moved");
  a_irq_masked: assert property (
    ack && avs_write && avs_address[9:2] == 8'h76 && !avs_writedata[0] |=> !irq)
    else $error("irq with mask off");
  a_irq_cleared: assert property (
    ack && avs_write && avs_address[9:2] == 8'h75 && avs_writedata[0] |=> !irq)
    else $error("irq after clear");
endmodule // lscsm_properties
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench of the clock shift meter
// assumes design and checker files compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clock = 1'b0, rst_n = 1'b0, ext_wake_clk = 1'b0, rc_wake_clk = 1'b0;
  logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, irq;
  logic [9:0]  avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [15:0] c;
  int          error_cnt = 0, checks = 0, ph = 0;
  logic [7:0]  idx [5] = '{8'h70, 8'h71, 8'h72, 8'h73, 8'h00};
  lscsm_top u_lscsm_top (.clock(clock), .rst_n(rst_n), .ext_wake_clk(ext_wake_clk),
    .rc_wake_clk(rc_wake_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  always #25 clock = ~clock;
  // wake clocks run in step with the master clock so the count is fixed; the check allows one either side of the expected value
  always @(posedge clock) begin
    ph <= ph + 1;
    ext_wake_clk <= (ph % 40) < 20;
    rc_wake_clk <= (ph % 60) < 30;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  // request held until the rising edge that sees waitrequest low; data taken there
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    int n;
    @(posedge clock);
    avs_address <= {i, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) error_cnt++;
    @(posedge clock);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic t_regs();
    foreach (idx[k]) begin
      bus(1'b0, idx[k], 8'h00);
      chk("reset", q, 32'h0);
    end
    bus(1'b1, 8'h72, 8'hff);
    bus(1'b0, 8'h72, 8'h00);
    chk("ro", q, 32'h0);
    bus(1'b1, 8'h70, 8'h50);
    bus(1'b0, 8'h70, 8'h00);
    chk("cfg", q, 32'h50);
  endtask
  task automatic t_meas(input logic s, input logic [3:0] dv, input logic [7:0] w, input int e);
    int n;
    bus(1'b1, 8'h2d, {5'h0, s, 2'h0});
    bus(1'b1, 8'h70, {dv, 4'h0});
    bus(1'b1, 8'h71, w);
    bus(1'b1, 8'h76, 8'h01);
    bus(1'b1, 8'h74, 8'h01);
    bus(1'b0, 8'h74, 8'h00);
    if (w != 0) chk("busy", q[1], 1'b1);
    n = 0;
    while (irq !== 1'b1 && n < 4000) begin
      @(negedge clock);
      n++;
    end
    chk("irq", irq, 1'b1);
    bus(1'b0, 8'h72, 8'h00);
    c[15:8] = q[7:0];
    bus(1'b0, 8'h73, 8'h00);
    c[7:0] = q[7:0];
    chk("count", (c + 32'd1 >= e) && (c <= e + 1), 1'b1);
    bus(1'b1, 8'h76, 8'h00);
    repeat (2) @(negedge clock);
    chk("mask", irq, 1'b0);
    bus(1'b1, 8'h75, 8'h01);
    bus(1'b0, 8'h75, 8'h00);
    chk("clear", q[0], 1'b0);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_regs();
    t_meas(1'b0, 4'h0, 8'h05, 200);
    t_meas(1'b0, 4'h4, 8'h05, 50);
    t_meas(1'b1, 4'h0, 8'h03, 180);
    t_meas(1'b0, 4'h0, 8'h00, 0);
    t_meas(1'b0, 4'h0, 8'h3f, 2520);
    stop_test();
  end
  initial begin
    #2000000;
    error_cnt++;
    stop_test();
  end
endmodule // tb_top
bind lscsm_top lscsm_properties u_lscsm_properties (.clock(clock), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq));
`default_nettype wire
